// *** sim_pkg.sv ***
// Package with constants and types of the supply integrity monitor
package sim_pkg;
    localparam logic [7:0] SIM_CSR_ADDR = 8'h00;
    localparam logic [7:0] SIM_CSR_RST = 8'h00;
    localparam int SIM_BIT_SRC = 7;
    localparam int SIM_BIT_IE = 6;
    localparam int SIM_BIT_WARN = 5;
    localparam int SIM_BIT_UVRF = 4;
    localparam int SIM_BIT_WDRF = 0;
    localparam logic [7:0] SIM_WR_MASK = 8'hD1;
    localparam int SIM_CLK_HZ = 10_000_000;
    localparam int SIM_RST_PULSE_NS = 20_000;
    localparam int SIM_RST_PULSE_CYC = (SIM_RST_PULSE_NS * (SIM_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SIM_DLY_SHORT_CYC = 256;
    localparam int SIM_DLY_LONG_CYC = 4096;
    localparam int SIM_CNT_W = 13;
    typedef enum logic [1:0] {
        SIM_RUN = 2'b00,
        SIM_HOLD = 2'b01,
        SIM_STRETCH = 2'b11
    } sim_rst_t;
endpackage : sim_pkg

// *** sim_sync_if.sv ***
// Interface carrying synchronised comparator levels
`timescale 1ns/1ps
`default_nettype none
interface sim_sync_if;
    logic warn_cmp;
    logic uv_cmp;
    modport src (output warn_cmp, output uv_cmp);
    modport dst (input warn_cmp, input uv_cmp);
endinterface : sim_sync_if
`default_nettype wire

// *** sim_sync.sv ***
// Three-stage synchroniser for both comparator outputs
`timescale 1ns/1ps
`default_nettype none
module sim_sync
    import sim_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic warn_raw_i,
    input wire logic uv_raw_i,
    sim_sync_if.src sy
);
    typedef struct packed {
        logic [2:0] w;
        logic [2:0] u;
        logic wo;
        logic uo;
    } sim_sync_st_t;
    sim_sync_st_t s_r;
    sim_sync_st_t s_nxt;
    always_comb begin
        s_nxt = s_r;
        s_nxt.w = {s_r.w[1:0], warn_raw_i};
        s_nxt.u = {s_r.u[1:0], uv_raw_i};
        // Change accepted only when stages two and three agree
        if (s_r.w[1] == s_r.w[2]) begin
            s_nxt.wo = s_r.w[2];
        end
        if (s_r.u[1] == s_r.u[2]) begin
            s_nxt.uo = s_r.u[2];
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign sy.warn_cmp = s_r.wo;
    assign sy.uv_cmp = s_r.uo;
endmodule : sim_sync
`default_nettype wire

// *** sim_top.sv ***
// Supply integrity monitor: reset holding, warning flag and interrupt, reset cause flags
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sim_top
    import sim_pkg::*;
#(
    parameter int RST_PULSE_CYC = SIM_RST_PULSE_CYC,
    parameter int DLY_LONG_CYC = SIM_DLY_LONG_CYC
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // Analog comparators and option settings
    input wire logic SUPPLY_WARN_CMP_I,
    input wire logic PIN_WARN_CMP_I,
    input wire logic UV_CMP_I,
    input wire logic UV_ENABLE_OPT_I,
    input wire logic [1:0] UV_LEVEL_OPT_I,
    input wire logic LONG_DELAY_OPT_I,
    output logic [1:0] UV_LEVEL_O,
    output logic WARN_SRC_O,
    // Reset sources and pin
    input wire logic WDG_UNDERFLOW_I,
    output logic RESET_PIN_O,
    output logic RESET_PIN_OE_O,
    // CPU interrupt side
    input wire logic CPU_IRQ_MASK_I,
    input wire logic IRQ_ACK_I,
    input wire logic HALT_I,
    input wire logic WAIT_I,
    output logic IRQ_O,
    output logic WAKE_O
);
    initial begin
        if (RST_PULSE_CYC < 1 || RST_PULSE_CYC >= (1 << SIM_CNT_W)) begin
            $error("RST_PULSE_CYC out of range");
        end
        if (DLY_LONG_CYC < SIM_DLY_SHORT_CYC || DLY_LONG_CYC >= (1 << SIM_CNT_W)) begin
            $error("DLY_LONG_CYC out of range");
        end
    end

    typedef struct packed {
        logic src;
        logic ie;
        logic warn;
        logic uvrf;
        logic wdrf;
        logic pend;
        logic [7:0] rdata;
        sim_rst_t rst;
        logic [SIM_CNT_W-1:0] pcnt;
        logic [SIM_CNT_W-1:0] scnt;
        logic startup;
    } sim_state_t;

    sim_state_t s_r;
    sim_state_t s_nxt;
    sim_sync_if sy();
    logic warn_raw;
    logic wr_csr;
    logic [SIM_CNT_W-1:0] dly_cyc;

    // Source mux sits ahead of the synchroniser so the selected level is what gets cleaned
    assign warn_raw = s_r.src ? PIN_WARN_CMP_I : SUPPLY_WARN_CMP_I;

    sim_sync u_sync (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .warn_raw_i(warn_raw),
        .uv_raw_i(UV_CMP_I),
        .sy(sy.src)
    );

    assign wr_csr = WR_I && (ADDR_I == SIM_CSR_ADDR);
    assign dly_cyc = LONG_DELAY_OPT_I ? SIM_CNT_W'(DLY_LONG_CYC) : SIM_CNT_W'(SIM_DLY_SHORT_CYC);

    function automatic logic [7:0] csr_val(input sim_state_t s);
        logic [7:0] v;
        v = 8'h00;
        v[SIM_BIT_SRC] = s.src;
        v[SIM_BIT_IE] = s.ie;
        v[SIM_BIT_WARN] = s.warn;
        v[SIM_BIT_UVRF] = s.uvrf;
        v[SIM_BIT_WDRF] = s.wdrf;
        return v;
    endfunction : csr_val

    always_comb begin
        logic warn_now;
        logic set_ev;
        warn_now = 1'b0;
        set_ev = 1'b0;
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        if (RD_I && ADDR_I == SIM_CSR_ADDR) begin
            s_nxt.rdata = csr_val(s_r);
        end
        // Reset pin sequencing
        case (s_r.rst)
            SIM_RUN: begin
                if (UV_ENABLE_OPT_I && sy.uv_cmp) begin
                    s_nxt.rst = SIM_HOLD;
                end else if (WDG_UNDERFLOW_I) begin
                    s_nxt.rst = SIM_STRETCH;
                    s_nxt.pcnt = SIM_CNT_W'(RST_PULSE_CYC - 1);
                end
            end
            SIM_HOLD: begin
                if (!(UV_ENABLE_OPT_I && sy.uv_cmp)) begin
                    s_nxt.rst = SIM_RUN;
                    s_nxt.startup = 1'b1;
                    s_nxt.scnt = dly_cyc;
                end
            end
            SIM_STRETCH: begin
                if (UV_ENABLE_OPT_I && sy.uv_cmp) begin
                    s_nxt.rst = SIM_HOLD;
                end else if (s_r.pcnt == '0) begin
                    s_nxt.rst = SIM_RUN;
                    s_nxt.startup = 1'b1;
                    s_nxt.scnt = dly_cyc;
                end else begin
                    s_nxt.pcnt = s_r.pcnt - 1'b1;
                end
            end
            default: begin
                s_nxt.rst = SIM_RUN;
            end
        endcase
        if (s_r.startup) begin
            if (s_r.scnt == '0) begin
                s_nxt.startup = 1'b0;
            end else begin
                s_nxt.scnt = s_r.scnt - 1'b1;
            end
        end
        // Reset cause flags: hardware sets win over software clears
        if (wr_csr) begin
            if (!WDATA_I[SIM_BIT_UVRF]) begin
                s_nxt.uvrf = 1'b0;
            end
            if (!WDATA_I[SIM_BIT_WDRF]) begin
                s_nxt.wdrf = 1'b0;
            end
        end
        if (s_r.rst == SIM_RUN && WDG_UNDERFLOW_I && !(UV_ENABLE_OPT_I && sy.uv_cmp)) begin
            s_nxt.wdrf = 1'b1;
        end
        if (s_r.rst != SIM_HOLD && UV_ENABLE_OPT_I && sy.uv_cmp) begin
            s_nxt.uvrf = 1'b1;
            s_nxt.wdrf = 1'b0;
        end
        if (s_r.rst != SIM_RUN) begin
            // Control bits go back to reset value while the chip is held in reset, except that HALT_I keeps src and ie
            s_nxt.src = 1'b0;
            s_nxt.ie = 1'b0;
            s_nxt.pend = 1'b0;
        end else begin
            if (wr_csr) begin
                s_nxt.src = WDATA_I[SIM_BIT_SRC];
                s_nxt.ie = WDATA_I[SIM_BIT_IE];
            end
            // Warning flag follows the synchronised comparator unless frozen by HALT_I, and is 0 while the detector is off
            warn_now = UV_ENABLE_OPT_I ? sy.warn_cmp : 1'b0;
            if (!HALT_I) begin
                s_nxt.warn = warn_now;
                // A clearing of the flag (supply rising) inside the startup delay is swallowed
                if (s_r.ie && (warn_now != s_r.warn) && !(s_r.startup && !warn_now)) begin
                    set_ev = 1'b1;
                end
            end
            if (wr_csr && WDATA_I[SIM_BIT_IE] && !s_r.ie && s_r.warn) begin
                set_ev = 1'b1;
            end
            if (IRQ_ACK_I) begin
                s_nxt.pend = 1'b0;
            end
            if (set_ev && UV_ENABLE_OPT_I) begin
                s_nxt.pend = 1'b1;
            end
        end
        if (HALT_I) begin
            // Control bits src and ie hold still, even while held in reset; no flag is frozen here
            s_nxt.src = s_r.src;
            s_nxt.ie = s_r.ie;
        end
        if (!UV_ENABLE_OPT_I) begin
            s_nxt.uvrf = 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign RDATA_O = s_r.rdata;
    assign RESET_PIN_O = 1'b0;
    assign RESET_PIN_OE_O = (s_r.rst != SIM_RUN);
    // Enable gates the request too, so clearing it silences a pending one
    assign IRQ_O = s_r.pend && s_r.ie && !CPU_IRQ_MASK_I;
    assign WAKE_O = IRQ_O && WAIT_I && !HALT_I;
    assign UV_LEVEL_O = UV_LEVEL_OPT_I;
    assign WARN_SRC_O = s_r.src;

    property p_uv_hold;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (UV_ENABLE_OPT_I && sy.uv_cmp) |=> RESET_PIN_OE_O;
    endproperty
    uv_reset_hold_a: assert property (p_uv_hold) else $error("reset pin not held under undervoltage");
    wdg_pulse_len_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        $rose(s_r.rst == SIM_STRETCH) |-> (s_r.rst == SIM_STRETCH)[*2])
        else $error("watchdog reset pulse too short");
    irq_mask_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        IRQ_O |-> (s_r.pend && !CPU_IRQ_MASK_I && s_r.ie)) else $error("irq without enable or unmasked");
    ack_clears_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (IRQ_ACK_I && s_r.rst == SIM_RUN && !wr_csr && !HALT_I
         && s_nxt.warn == s_r.warn) |=> !s_r.pend) else $error("ack did not clear request");
    toggle_irq_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (s_r.rst == SIM_RUN && s_r.ie && !HALT_I && UV_ENABLE_OPT_I && !s_r.startup && s_r.warn && !sy.warn_cmp)
        |=> s_r.pend) else $error("falling comparator missed interrupt");
    halt_freeze_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (HALT_I && s_r.rst == SIM_RUN) |=> $stable(s_r.warn)) else $error("flag moved in halt");
    uv_clears_wd_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (s_r.rst == SIM_RUN && UV_ENABLE_OPT_I && sy.uv_cmp) |=> (s_r.uvrf && !s_r.wdrf))
        else $error("undervoltage reset flags wrong");
    wd_flag_set_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (s_r.rst == SIM_RUN && WDG_UNDERFLOW_I && !(UV_ENABLE_OPT_I && sy.uv_cmp)) |=> s_r.wdrf)
        else $error("watchdog flag not set");
    uvrf_kept_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (s_r.uvrf && UV_ENABLE_OPT_I && !wr_csr) |=> s_r.uvrf) else $error("undervoltage flag lost");
    warn_off_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !UV_ENABLE_OPT_I [*2] |-> !s_r.warn) else $error("warning active with detector off");
    rsvd_zero_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        RDATA_O[3:1] == 3'h0) else $error("reserved bits nonzero");
    cov_uv_c: cover property (@(posedge CLK_I) disable iff (!RST_N_I) $rose(s_r.rst == SIM_HOLD));
    cov_wdg_c: cover property (@(posedge CLK_I) disable iff (!RST_N_I) $fell(s_r.rst == SIM_STRETCH));
    cov_irq_c: cover property (@(posedge CLK_I) disable iff (!RST_N_I) IRQ_O ##1 IRQ_ACK_I);
    cov_pin_c: cover property (@(posedge CLK_I) disable iff (!RST_N_I) s_r.src && $rose(s_r.pend));
endmodule : sim_top
`default_nettype wire

// *** sim_cmp_model.sv ***
// Behavioural comparators with hysteresis at the far side of the monitor
`timescale 1ns/1ps
`default_nettype none
module sim_cmp_model #(
    parameter int WARN_LO = 3900,
    parameter int WARN_HI = 4000,
    parameter int UV_LO = 3600,
    parameter int UV_HI = 3700
) (
    // Levels in millivolts
    input var int supply_mv_i,
    input var int pin_mv_i,
    // Comparator outputs, 1 means below
    output logic supply_warn_o,
    output logic pin_warn_o,
    output logic uv_o
);
    // Lower threshold on the way down, upper on the way up, hold in between
    function automatic logic hyst(input int v, input int lo, input int hi, input logic last);
        return (v < lo) ? 1'b1 : ((v > hi) ? 1'b0 : last);
    endfunction : hyst
    initial begin
        supply_warn_o = 1'b0;
        pin_warn_o = 1'b0;
        uv_o = 1'b0;
    end
    always @(supply_mv_i) begin
        supply_warn_o = hyst(supply_mv_i, WARN_LO, WARN_HI, supply_warn_o);
        uv_o = hyst(supply_mv_i, UV_LO, UV_HI, uv_o);
    end
    always @(pin_mv_i) begin
        pin_warn_o = hyst(pin_mv_i, WARN_LO, WARN_HI, pin_warn_o);
    end
endmodule : sim_cmp_model
`default_nettype wire

// *** sim_top_tb_top.sv ***
// Self-checking testbench of the supply integrity monitor
`timescale 1ns/1ps
`default_nettype none
module sim_top_tb_top
    import sim_pkg::*;
;
    localparam int RPC = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic uv_en = 1'b1;
    logic [1:0] lvl = 2'h0;
    logic wdg = 1'b0;
    logic mask = 1'b0;
    logic ack = 1'b0;
    logic halt = 1'b0;
    logic wt = 1'b0;
    logic ldly = 1'b0;
    int supply_mv;
    int pin_mv;
    logic sup_cmp, pin_cmp, uv_cmp, src_o, pin_o, oe, irq, wake;
    logic [7:0] rdata;
    logic [1:0] lvl_o;
    int miscompares = 0;
    int samples_checked = 0;
    sim_cmp_model cmp (.supply_mv_i(supply_mv), .pin_mv_i(pin_mv), .supply_warn_o(sup_cmp),
        .pin_warn_o(pin_cmp), .uv_o(uv_cmp));
    sim_top #(.RST_PULSE_CYC(RPC), .DLY_LONG_CYC(300)) dut (.CLK_I(clk), .RST_N_I(rst_n),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .SUPPLY_WARN_CMP_I(sup_cmp), .PIN_WARN_CMP_I(pin_cmp), .UV_CMP_I(uv_cmp),
        .UV_ENABLE_OPT_I(uv_en), .UV_LEVEL_OPT_I(lvl), .LONG_DELAY_OPT_I(ldly), .UV_LEVEL_O(lvl_o),
        .WARN_SRC_O(src_o), .WDG_UNDERFLOW_I(wdg), .RESET_PIN_O(pin_o), .RESET_PIN_OE_O(oe),
        .CPU_IRQ_MASK_I(mask), .IRQ_ACK_I(ack), .HALT_I(halt), .WAIT_I(wt), .IRQ_O(irq), .WAKE_O(wake));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("csr read", rdata, exp);
    endtask : rd_reg
    task automatic pulse(input bit on_wdg);
        @(posedge clk);
        if (on_wdg) wdg <= 1'b1;
        else ack <= 1'b1;
        @(posedge clk);
        wdg <= 1'b0;
        ack <= 1'b0;
    endtask : pulse
    // Bounded wait so a stuck output is reported instead of hanging the run
    task automatic wait_on(input bit use_oe, input logic v);
        #1;
        for (int i = 0; i < 40; i++) begin
            if ((use_oe ? oe : irq) === v) break;
            cyc(1);
        end
        chk(use_oe ? "reset pin enable" : "irq", {7'h00, use_oe ? oe : irq}, {7'h00, v});
    endtask : wait_on
    task automatic wdg_reset();
        int n;
        pulse(1'b1);
        wait_on(1'b1, 1'b1);
        n = 0;
        while (oe === 1'b1 && n < 50) begin
            n++;
            cyc(1);
        end
        chk("reset pulse width", {7'h00, n >= RPC}, 8'h01);
    endtask : wdg_reset
    initial begin
        supply_mv <= 3800;
        pin_mv <= 5000;
        cyc(3);
        chk("rdata in reset", rdata, SIM_CSR_RST);
        chk("oe in reset", {7'h00, oe | irq}, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        cyc(8);
        rd_reg(SIM_CSR_ADDR, 8'h20);
        wr_reg(SIM_CSR_ADDR, 8'h40);
        wait_on(1'b0, 1'b1);
        pulse(1'b0);
        wait_on(1'b0, 1'b0);
        supply_mv = 4100;
        wait_on(1'b0, 1'b1);
        pulse(1'b0);
        wait_on(1'b0, 1'b0);
        wr_reg(SIM_CSR_ADDR, 8'hF1);
        rd_reg(SIM_CSR_ADDR, 8'hC0);
        rd_reg(8'h01, 8'h00);
        chk("source out", {7'h00, src_o}, 8'h01);
        supply_mv = 3800;
        cyc(10);
        rd_reg(SIM_CSR_ADDR, 8'hC0);
        pin_mv = 3000;
        wait_on(1'b0, 1'b1);
        rd_reg(SIM_CSR_ADDR, 8'hE0);
        @(posedge clk);
        wt <= 1'b1;
        cyc(1);
        chk("wake in wait", {7'h00, wake}, 8'h01);
        halt <= 1'b1;
        cyc(1);
        chk("no wake in halt", {7'h00, wake}, 8'h00);
        halt <= 1'b0;
        mask <= 1'b1;
        cyc(1);
        chk("masked irq", {7'h00, irq}, 8'h00);
        mask <= 1'b0;
        wt <= 1'b0;
        pulse(1'b0);
        wait_on(1'b0, 1'b0);
        pin_mv = 5000;
        wait_on(1'b0, 1'b1);
        pulse(1'b0);
        @(posedge clk);
        halt <= 1'b1;
        pin_mv = 3000;
        cyc(10);
        rd_reg(SIM_CSR_ADDR, 8'hC0);
        wr_reg(SIM_CSR_ADDR, 8'h00);
        rd_reg(SIM_CSR_ADDR, 8'hC0);
        @(posedge clk);
        halt <= 1'b0;
        wait_on(1'b0, 1'b1);
        rd_reg(SIM_CSR_ADDR, 8'hE0);
        @(posedge clk);
        uv_en <= 1'b0;
        cyc(8);
        pulse(1'b0);
        pin_mv = 5000;
        cyc(10);
        pin_mv = 3000;
        cyc(10);
        chk("irq while disabled", {7'h00, irq}, 8'h00);
        rd_reg(SIM_CSR_ADDR, 8'hC0);
        @(posedge clk);
        uv_en <= 1'b1;
        supply_mv = 4100;
        pin_mv = 5000;
        cyc(10);
        wdg_reset();
        rd_reg(SIM_CSR_ADDR, 8'h01);
        wr_reg(SIM_CSR_ADDR, 8'h00);
        rd_reg(SIM_CSR_ADDR, 8'h00);
        wdg_reset();
        ldly <= 1'b1;
        supply_mv = 3500;
        wait_on(1'b1, 1'b1);
        supply_mv = 3650;
        cyc(20);
        chk("held in hysteresis", {7'h00, oe}, 8'h01);
        // Leave static reset still inside the warning band, then rise inside the startup window
        supply_mv = 3800;
        wait_on(1'b1, 1'b0);
        cyc(8);
        rd_reg(SIM_CSR_ADDR, 8'h30);
        wr_reg(SIM_CSR_ADDR, 8'h50);
        wait_on(1'b0, 1'b1);
        pulse(1'b0);
        wait_on(1'b0, 1'b0);
        supply_mv = 4100;
        cyc(20);
        chk("no rise irq in startup", {7'h00, irq}, 8'h00);
        wdg_reset();
        rd_reg(SIM_CSR_ADDR, 8'h11);
        wr_reg(SIM_CSR_ADDR, 8'h00);
        rd_reg(SIM_CSR_ADDR, 8'h00);
        for (int i = 0; i < 4; i++) begin
            lvl <= i[1:0];
            cyc(1);
            chk("level out", {6'h00, lvl_o}, i[7:0]);
        end
        chk("reset pin level", {7'h00, pin_o}, 8'h00);
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule : sim_top_tb_top
`default_nettype wire
